// ---- logic/scan_port_defines.vh ----
// Constants for the boundary-scan test access port.
// Assumes inclusion by the port module only; definitions only.
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH

// ----------------------------------------------------------------
// Register lengths
// ----------------------------------------------------------------
`define IR_LEN 3
`define ID_LEN 32
`define BSR_LEN 98
`define OBS_LEN 62

// ----------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------
`define IR_EXTEST 3'h0
`define IR_IDCODE 3'h1
`define IR_SAMPLE 3'h2
`define IR_SCANTEST 3'h5
`define IR_CAPTURE 3'h1

// ----------------------------------------------------------------
// Chain positions of the driven cells
// ----------------------------------------------------------------
`define CELL_FRAME_EN 0
`define CELL_FRAME 1
`define CELL_XFER 13
`define CELL_SOC 14
`define CELL_RXAV_EN 17
`define CELL_RXAV 18
`define CELL_PARITY 19
`define CELL_WORD_HI 20
`define CELL_RXBUS_EN 35
`define CELL_WORD0 36
`define CELL_TXAV_EN 57
`define CELL_TXAV 58
`define CELL_DATA_EN 87
`define CELL_DATA0 88
`define CELL_IRQ 96

// ----------------------------------------------------------------
// Pin input conditioning
// ----------------------------------------------------------------
`define SYNC_STAGES 3

`endif

// ---- logic/scan_port.v ----
// Boundary-scan test access port with a 98-cell chain around the pins.
// Assumes a tester drives the scan pins slowly against i_clk_sys
// (20 MHz); all scan pins are sampled, no scan clock domain exists.
//
// Function
// - Controller plus four paths: IR, bypass, ID, boundary
// - Capture inputs, force outputs, read device identity
// - Bypass shortens serial path to one bit
// - Decode EXTEST, IDCODE, SAMPLE, scan test codes
// - Codes 011, 100, 110, 111 select bypass
// - 32-bit ID: version, part, maker fields
// - 98 cells; cell 0 nearest serial output
// - Cell 35 gates whole receive bus group
// - Cells 17 and 57 gate own outputs
// - Transmit-available enable active low, one floats
// - Interrupt cell high means pin floats
// - Frame reference enable active low, output cell 1
// - Chain clocks only in shift and capture
// - Per-cell three-way mux from two selects
// - Standard five-signal scan interface
// - Serial pairs unscanned; other pins covered
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"

module scan_port #(
    parameter [3:0] ID_VERSION = 4'h1,   // Arbitrary value
    parameter [15:0] ID_PART = 16'h2b5e, // Arbitrary value
    parameter [10:0] ID_MAKER = 11'h0a3  // Arbitrary value
) (
    // System clock and reset
    input wire i_clk_sys,
    input wire i_reset_n,
    // Scan pins
    input wire i_tck,
    input wire i_tms,
    input wire i_tdi,
    input wire i_trst_n,
    output wire o_tdo,
    output wire o_tdo_oe,
    // Core side of driven pins
    input wire i_rx_frame_ref_out,
    input wire i_rx_frame_ref_drive_en_n,
    input wire i_rx_start_of_xfer,
    input wire i_rx_start_of_cell,
    input wire i_rx_avail_drive_en_n,
    input wire i_rx_cell_available,
    input wire i_rx_parity,
    input wire [15:0] i_rx_bus_word,
    input wire i_rx_bus_drive_en_n,
    input wire i_tx_avail_drive_en_n,
    input wire i_tx_cell_available,
    input wire [7:0] i_data_bus_out,
    input wire i_data_bus_drive_en_n,
    input wire i_irq_out_n,
    // Observed input pins, in chain order
    input wire [`OBS_LEN-1:0] i_pin_obs,
    input wire [7:0] i_pin_data,
    // Pin side of driven pins
    output wire o_rx_frame_ref_out,
    output wire o_rx_frame_ref_oe,
    output wire o_rx_start_of_xfer,
    output wire o_rx_start_of_cell,
    output wire o_rx_parity,
    output wire [15:0] o_rx_bus_word,
    output wire o_rx_bus_oe,
    output wire o_rx_cell_available,
    output wire o_rx_avail_oe,
    output wire o_tx_cell_available,
    output wire o_tx_avail_oe,
    output wire [7:0] o_data_bus,
    output wire o_data_bus_oe,
    output wire o_irq_out,
    output wire o_irq_oe
);

    // ------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------
    localparam [3:0] ST_EXIT2_DR = 4'h0;
    localparam [3:0] ST_EXIT1_DR = 4'h1;
    localparam [3:0] ST_SHIFT_DR = 4'h2;
    localparam [3:0] ST_PAUSE_DR = 4'h3;
    localparam [3:0] ST_SEL_IR = 4'h4;
    localparam [3:0] ST_UPD_DR = 4'h5;
    localparam [3:0] ST_CAP_DR = 4'h6;
    localparam [3:0] ST_SEL_DR = 4'h7;
    localparam [3:0] ST_EXIT2_IR = 4'h8;
    localparam [3:0] ST_EXIT1_IR = 4'h9;
    localparam [3:0] ST_SHIFT_IR = 4'ha;
    localparam [3:0] ST_PAUSE_IR = 4'hb;
    localparam [3:0] ST_IDLE = 4'hc;
    localparam [3:0] ST_UPD_IR = 4'hd;
    localparam [3:0] ST_CAP_IR = 4'he;
    localparam [3:0] ST_RESET = 4'hf;

    // ------------------------------------------------------------
    // Pin conditioning: three stages, change on agreement
    // ------------------------------------------------------------
    reg [3:0] sync1_q, sync2_q, sync3_q, pin_q;
    wire [3:0] pin_raw = {i_trst_n, i_tdi, i_tms, i_tck};
    wire [3:0] pin_d = (sync2_q == sync3_q) ? sync3_q : pin_q;

    // Synchroniser chain and filtered levels
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sync1_q <= 4'h8;
            sync2_q <= 4'h8;
            sync3_q <= 4'h8;
            pin_q <= 4'h8;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            pin_q <= pin_d;
        end
    end

    wire tck_rise = pin_d[0] & ~pin_q[0];
    wire tck_fall = ~pin_d[0] & pin_q[0];
    wire tms = pin_d[1];
    wire tdi = pin_d[2];
    wire trst_n = pin_d[3];

    // ------------------------------------------------------------
    // Controller
    // ------------------------------------------------------------
    reg [3:0] state_q, state_d;

    // Sixteen-state next-state table
    always @* begin
        case (state_q)
            ST_RESET: state_d = tms ? ST_RESET : ST_IDLE;
            ST_IDLE: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: state_d = tms ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_SHIFT_DR: state_d = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
            ST_EXIT1_DR: state_d = tms ? ST_UPD_DR : ST_PAUSE_DR;
            ST_PAUSE_DR: state_d = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
            ST_EXIT2_DR: state_d = tms ? ST_UPD_DR : ST_SHIFT_DR;
            ST_UPD_DR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: state_d = tms ? ST_RESET : ST_CAP_IR;
            ST_CAP_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_SHIFT_IR: state_d = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
            ST_EXIT1_IR: state_d = tms ? ST_UPD_IR : ST_PAUSE_IR;
            ST_PAUSE_IR: state_d = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
            ST_EXIT2_IR: state_d = tms ? ST_UPD_IR : ST_SHIFT_IR;
            ST_UPD_IR: state_d = tms ? ST_SEL_DR : ST_IDLE;
            default: state_d = ST_RESET;
        endcase
    end

    // State register, stepped on scan clock rise
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state_q <= ST_RESET;
        end else if (!trst_n) begin
            state_q <= ST_RESET;
        end else if (tck_rise) begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // Instruction register and decode
    // ------------------------------------------------------------
    reg [`IR_LEN-1:0] ir_sh_q, ir_q;

    // Shift stage and latched instruction
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ir_sh_q <= `IR_IDCODE;
            ir_q <= `IR_IDCODE;
        end else if (!trst_n || state_q == ST_RESET) begin
            ir_q <= `IR_IDCODE;
            ir_sh_q <= `IR_IDCODE;
        end else if (tck_rise && state_q == ST_CAP_IR) begin
            ir_sh_q <= `IR_CAPTURE;
        end else if (tck_rise && state_q == ST_SHIFT_IR) begin
            ir_sh_q <= {tdi, ir_sh_q[`IR_LEN-1:1]};
        end else if (tck_fall && state_q == ST_UPD_IR) begin
            ir_q <= ir_sh_q;
        end
    end

    // Path selection from the instruction
    wire sel_id = (ir_q == `IR_IDCODE);
    wire sel_bsr = (ir_q == `IR_EXTEST) || (ir_q == `IR_SAMPLE) ||
        (ir_q == `IR_SCANTEST);
    wire sel_byp = !sel_id && !sel_bsr;
    wire extest = (ir_q == `IR_EXTEST);

    // ------------------------------------------------------------
    // Bypass and identification paths
    // ------------------------------------------------------------
    reg byp_q;
    reg [`ID_LEN-1:0] id_q;
    wire dr_cap = tck_rise && state_q == ST_CAP_DR;
    wire dr_shift = tck_rise && state_q == ST_SHIFT_DR;

    // Single bypass bit and identity shifter
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            byp_q <= 1'b0;
            id_q <= {`ID_LEN{1'b0}};
        end else begin
            if (sel_byp && dr_cap) begin
                byp_q <= 1'b0;
            end else if (sel_byp && dr_shift) begin
                byp_q <= tdi;
            end
            if (sel_id && dr_cap) begin
                id_q <= {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
            end else if (sel_id && dr_shift) begin
                id_q <= {tdi, id_q[`ID_LEN-1:1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Boundary chain: parallel image of the pins
    // ------------------------------------------------------------
    reg [`BSR_LEN-1:0] cap_v;
    integer k;

    // Capture values; serial pairs have no cells
    always @* begin
        cap_v = {`BSR_LEN{1'b0}};
        cap_v[11:0] = {i_pin_obs[9:0], i_rx_frame_ref_out,
            i_rx_frame_ref_drive_en_n};
        cap_v[`CELL_XFER-1 + 0] = i_pin_obs[10];
        cap_v[`CELL_XFER] = i_rx_start_of_xfer;
        cap_v[`CELL_SOC] = i_rx_start_of_cell;
        cap_v[16:15] = i_pin_obs[12:11];
        cap_v[`CELL_RXAV_EN] = i_rx_avail_drive_en_n;
        cap_v[`CELL_RXAV] = i_rx_cell_available;
        cap_v[`CELL_PARITY] = i_rx_parity;
        for (k = 1; k < 16; k = k + 1) begin
            cap_v[`CELL_WORD_HI + 15 - k] = i_rx_bus_word[k];
        end
        cap_v[`CELL_RXBUS_EN] = i_rx_bus_drive_en_n;
        cap_v[`CELL_WORD0] = i_rx_bus_word[0];
        cap_v[56:37] = i_pin_obs[32:13];
        cap_v[`CELL_TXAV_EN] = i_tx_avail_drive_en_n;
        cap_v[`CELL_TXAV] = i_tx_cell_available;
        cap_v[86:59] = i_pin_obs[60:33];
        cap_v[`CELL_DATA_EN] = i_data_bus_drive_en_n;
        cap_v[95:88] = i_pin_data;
        cap_v[`CELL_IRQ] = i_irq_out_n;
        cap_v[97] = i_pin_obs[61];
    end

    // Cell selects: capture on 01, shift on 10, else hold
    wire g1 = sel_bsr && state_q == ST_CAP_DR;
    wire g2 = sel_bsr && state_q == ST_SHIFT_DR;
    wire clock_dr = tck_rise && (g1 || g2);
    reg [`BSR_LEN-1:0] bsr_q, upd_q;
    wire [`BSR_LEN-1:0] bsr_d;

    // Three-way mux per cell; tdi enters the far end
    genvar c;
    generate
        for (c = 0; c < `BSR_LEN; c = c + 1) begin : g_cell
            wire nbr = (c == `BSR_LEN - 1) ? tdi : bsr_q[(c + 1) % `BSR_LEN];
            assign bsr_d[c] = ({g2, g1} == 2'b01) ? cap_v[c] :
                ({g2, g1} == 2'b10) ? nbr : bsr_q[c];
        end
    endgenerate

    // Shift stage and update latch of the chain
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bsr_q <= {`BSR_LEN{1'b0}};
            upd_q <= {`BSR_LEN{1'b1}};
        end else begin
            if (clock_dr) begin
                bsr_q <= bsr_d;
            end
            if (sel_bsr && tck_fall && state_q == ST_UPD_DR) begin
                upd_q <= bsr_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Serial output, changed on scan clock fall
    // ------------------------------------------------------------
    reg tdo_q, tdo_oe_q;
    wire dr_bit = sel_bsr ? bsr_q[0] : (sel_id ? id_q[0] : byp_q);

    // Drive only while shifting
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_q <= (state_q == ST_SHIFT_IR) ? ir_sh_q[0] : dr_bit;
            tdo_oe_q <= (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);
        end
    end

    assign o_tdo = tdo_q;
    assign o_tdo_oe = tdo_oe_q;

    // ------------------------------------------------------------
    // Pin drive: core in normal use, update latch under EXTEST
    // ------------------------------------------------------------
    wire [`BSR_LEN-1:0] drv = extest ? upd_q : cap_v;

    // Frame reference pin and its own enable
    assign o_rx_frame_ref_out = drv[`CELL_FRAME];
    assign o_rx_frame_ref_oe = ~drv[`CELL_FRAME_EN];

    // Receive bus group under one enable
    assign o_rx_start_of_xfer = drv[`CELL_XFER];
    assign o_rx_start_of_cell = drv[`CELL_SOC];
    assign o_rx_parity = drv[`CELL_PARITY];
    assign o_rx_bus_oe = ~drv[`CELL_RXBUS_EN];
    generate
        for (c = 0; c < 16; c = c + 1) begin : g_word
            assign o_rx_bus_word[c] = (c == 0) ? drv[`CELL_WORD0] :
                drv[`CELL_WORD_HI + 15 - c];
        end
    endgenerate

    // Availability pins, each with its own enable
    assign o_rx_cell_available = drv[`CELL_RXAV];
    assign o_rx_avail_oe = ~drv[`CELL_RXAV_EN];
    assign o_tx_cell_available = drv[`CELL_TXAV];
    assign o_tx_avail_oe = ~drv[`CELL_TXAV_EN];

    // Data bus, one enable for all eight bits
    assign o_data_bus = extest ? upd_q[95:88] : i_data_bus_out;
    assign o_data_bus_oe = ~drv[`CELL_DATA_EN];

    // Interrupt pin pulls low only, high floats
    assign o_irq_out = 1'b0;
    assign o_irq_oe = ~drv[`CELL_IRQ];

endmodule // scan_port

`default_nettype wire

// ---- bench/scan_port_checker.sv ----
// Concurrent checks on the scan port pins and serial output.
// Assumes binding into scan_port; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module scan_port_checker (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Scan pins
    input wire logic i_tck,
    input wire logic o_tdo,
    input wire logic o_tdo_oe,
    // Enables and pin drivers
    input wire logic i_rx_bus_drive_en_n,
    input wire logic o_rx_bus_oe,
    input wire logic i_rx_avail_drive_en_n,
    input wire logic o_rx_avail_oe,
    input wire logic i_tx_avail_drive_en_n,
    input wire logic o_tx_avail_oe,
    input wire logic i_data_bus_drive_en_n,
    input wire logic o_data_bus_oe,
    input wire logic i_irq_out_n,
    input wire logic o_irq_out,
    input wire logic o_irq_oe,
    input wire logic i_rx_frame_ref_drive_en_n,
    input wire logic o_rx_frame_ref_oe
);
    logic seen_q;
    logic [1:0] high_q;
    // --------------------------------
    // Helpers and assertions
    // --------------------------------
    // Scan clock seen since reset, and length of its high run
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            seen_q <= 1'b0;
            high_q <= 2'h0;
        end else begin
            seen_q <= seen_q | i_tck;
            high_q <= !i_tck ? 2'h0 : (high_q == 2'h3 ? 2'h3 : high_q + 2'h1);
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    sequence tck_settled;
        i_tck && high_q == 2'h3;
    endsequence
    sequence func_mode;
        !seen_q;
    endsequence
    tdo_hold_a: assert property (tck_settled |-> $stable(o_tdo))
        else $error("serial output moved while scan clock high");
    tdo_oe_hold_a: assert property (tck_settled |-> $stable(o_tdo_oe))
        else $error("serial enable moved while scan clock high");
    irq_low_a: assert property (o_irq_out == 1'b0)
        else $error("interrupt pin driven high");
    irq_func_a: assert property (func_mode |-> o_irq_oe == !i_irq_out_n)
        else $error("interrupt enable wrong");
    rxbus_func_a: assert property (func_mode |-> o_rx_bus_oe == !i_rx_bus_drive_en_n)
        else $error("receive bus enable wrong");
    avail_func_a: assert property (func_mode |->
        o_rx_avail_oe == !i_rx_avail_drive_en_n && o_tx_avail_oe == !i_tx_avail_drive_en_n)
        else $error("available enables wrong");
    data_func_a: assert property (func_mode |-> o_data_bus_oe == !i_data_bus_drive_en_n)
        else $error("data bus enable wrong");
    frame_func_a: assert property (func_mode |->
        o_rx_frame_ref_oe == !i_rx_frame_ref_drive_en_n)
        else $error("frame reference enable wrong");
endmodule // scan_port_checker
bind scan_port scan_port_checker chk (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_tck(i_tck), .o_tdo(o_tdo),
    .o_tdo_oe(o_tdo_oe), .i_rx_bus_drive_en_n(i_rx_bus_drive_en_n), .o_rx_bus_oe(o_rx_bus_oe),
    .i_rx_avail_drive_en_n(i_rx_avail_drive_en_n), .o_rx_avail_oe(o_rx_avail_oe),
    .i_tx_avail_drive_en_n(i_tx_avail_drive_en_n), .o_tx_avail_oe(o_tx_avail_oe),
    .i_data_bus_drive_en_n(i_data_bus_drive_en_n), .o_data_bus_oe(o_data_bus_oe),
    .i_irq_out_n(i_irq_out_n), .o_irq_out(o_irq_out), .o_irq_oe(o_irq_oe),
    .i_rx_frame_ref_drive_en_n(i_rx_frame_ref_drive_en_n), .o_rx_frame_ref_oe(o_rx_frame_ref_oe)
);
`default_nettype wire

// ---- bench/scan_tester.sv ----
// Board tester model driving the scan pins.
// Assumes a 400 ns scan clock paced by the system clock.
`timescale 1ns/1ps
`default_nettype none
module scan_tester (
    // Pacing clock and serial return
    input wire logic i_clk_sys,
    input wire logic i_tdo,
    // Scan pins
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    output logic o_trst_n
);
    // Pins idle with the scan clock still
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        o_trst_n = 1'b1;
    end
    // One scan clock; sample return, drop clock, set mode and data, raise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        begin
            @(posedge i_clk_sys);
            tdo = i_tdo;
            o_tck <= 1'b0;
            o_tms <= tms;
            o_tdi <= tdi;
            repeat (4) @(posedge i_clk_sys);
            o_tck <= 1'b1;
            repeat (3) @(posedge i_clk_sys);
        end
    endtask
    // Return to reset state by five mode ones, after a pin pulse if asked, then idle
    task automatic reset_tap(input logic use_pin);
        logic b;
        begin
            if (use_pin) begin
                @(posedge i_clk_sys);
                o_trst_n <= 1'b0;
                repeat (8) @(posedge i_clk_sys);
                o_trst_n <= 1'b1;
                repeat (6) @(posedge i_clk_sys);
            end
            repeat (5) step(1'b1, 1'b0, b);
            step(1'b0, 1'b0, b);
        end
    endtask
    // Full instruction or data scan from idle back to idle, low bit first
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic b;
        begin
            dout = '0;
            step(1'b1, 1'b0, b);
            if (ir) step(1'b1, 1'b0, b);
            step(1'b0, 1'b0, b);
            step(1'b0, 1'b0, b);
            for (int i = 0; i < n; i++) begin
                step(i == n - 1, din[i], b);
                if (i > 0) dout[i - 1] = b;
            end
            step(1'b1, 1'b0, b);
            dout[n - 1] = b;
            step(1'b0, 1'b0, b);
        end
    endtask
endmodule // scan_tester
`default_nettype wire

// ---- bench/scan_port_test.sv ----
// Self-checking bench for the scan port.
// Assumes scan_tester drives the scan pins and the checker is bound.
`timescale 1ns/1ps
`default_nettype none
module scan_port_test;
    localparam logic [3:0] ID_VER = 4'h1; // Arbitrary value
    localparam logic [15:0] ID_PRT = 16'h2b5e; // Arbitrary value
    localparam logic [10:0] ID_MFR = 11'h0a3; // Arbitrary value
    localparam logic [97:0] PAT_A = 98'h2a5c396f01e87b4d2c3a169e5;
    localparam logic [97:0] EN_MASK = 98'h8000000200000800020001;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic [97:0] pv = 98'h0;
    logic [127:0] got;
    int n_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    wire tck, tms, tdi, trst_n, tdo, tdo_oe;
    wire tdo_pin = tdo_oe ? tdo : 1'b1; // Pull-up holds a released line high
    wire [15:0] word_w;
    wire [35:0] pin_w;
    // --------------------------------
    // Pin map in chain order
    // --------------------------------
    function automatic logic [15:0] word_of(input logic [97:0] v);
        for (int i = 1; i < 16; i++) word_of[i] = v[35 - i];
        word_of[0] = v[36];
    endfunction
    function automatic logic [35:0] pins_of(input logic [97:0] v);
        pins_of = {~v[96], ~v[87], v[95:88], ~v[57], v[58], ~v[35], word_of(v), v[19],
                   v[18], ~v[17], v[14], v[13], ~v[0], v[1]};
    endfunction
    assign word_w = word_of(pv);
    always #25 clk_sys = ~clk_sys;
    scan_port #(.ID_VERSION(ID_VER), .ID_PART(ID_PRT), .ID_MAKER(ID_MFR)) uut (
        .i_clk_sys(clk_sys), .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_trst_n(trst_n), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_rx_frame_ref_out(pv[1]),
        .i_rx_frame_ref_drive_en_n(pv[0]), .i_rx_start_of_xfer(pv[13]),
        .i_rx_start_of_cell(pv[14]), .i_rx_avail_drive_en_n(pv[17]),
        .i_rx_cell_available(pv[18]), .i_rx_parity(pv[19]), .i_rx_bus_word(word_w),
        .i_rx_bus_drive_en_n(pv[35]), .i_tx_avail_drive_en_n(pv[57]),
        .i_tx_cell_available(pv[58]), .i_data_bus_out(pv[95:88]),
        .i_data_bus_drive_en_n(pv[87]), .i_irq_out_n(pv[96]),
        .i_pin_obs({pv[97], pv[86:59], pv[56:37], pv[16:15], pv[12:2]}),
        .i_pin_data(pv[95:88]), .o_irq_oe(pin_w[35]), .o_data_bus_oe(pin_w[34]),
        .o_data_bus(pin_w[33:26]), .o_tx_avail_oe(pin_w[25]), .o_tx_cell_available(pin_w[24]),
        .o_rx_bus_oe(pin_w[23]), .o_rx_bus_word(pin_w[22:7]), .o_rx_parity(pin_w[6]),
        .o_rx_cell_available(pin_w[5]), .o_rx_avail_oe(pin_w[4]),
        .o_rx_start_of_cell(pin_w[3]), .o_rx_start_of_xfer(pin_w[2]),
        .o_rx_frame_ref_oe(pin_w[1]), .o_rx_frame_ref_out(pin_w[0]), .o_irq_out()
    );
    scan_tester tester (.i_clk_sys(clk_sys), .i_tdo(tdo_pin), .o_tck(tck), .o_tms(tms),
        .o_tdi(tdi), .o_trst_n(trst_n));
    // --------------------------------
    // Helpers and scenarios
    // --------------------------------
    task automatic compare(input logic [127:0] g, input logic [127:0] e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apply(input logic [97:0] v);
        @(posedge clk_sys);
        pv <= v;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic t_func;
        for (int k = 0; k < 2; k++) begin
            apply(k ? ~PAT_A : PAT_A);
            compare(128'(pin_w), 128'(pins_of(pv)));
        end
    endtask
    task automatic t_idcode;
        tester.reset_tap(1'b1);
        tester.scan(1'b0, 32, 128'h0, got);
        compare(got, 128'({ID_VER, ID_PRT, ID_MFR, 1'b1}));
        tester.scan(1'b1, 3, 128'h1, got);
        compare(got, 128'h1);
    endtask
    task automatic t_bypass;
        for (int c = 3; c < 8; c++) begin
            if (c != 5) begin
                tester.scan(1'b1, 3, 128'(c), got);
                tester.scan(1'b0, 8, 128'hb5, got);
                compare(got, 128'h6a);
            end
        end
    endtask
    task automatic t_chain;
        for (int k = 0; k < 2; k++) begin
            apply(k ? ~PAT_A : PAT_A);
            tester.scan(1'b1, 3, k ? 128'h5 : 128'h2, got);
            tester.scan(1'b0, 100, 128'h2, got);
            compare(got, 128'({2'b10, pv}));
            compare(128'(pin_w), 128'(pins_of(pv)));
        end
    endtask
    task automatic t_extest;
        logic [97:0] v;
        tester.scan(1'b1, 3, 128'h0, got);
        for (int k = 0; k < 2; k++) begin
            v = k ? ~(PAT_A & ~EN_MASK) : PAT_A & ~EN_MASK;
            apply(~v);
            tester.scan(1'b0, 98, 128'(v), got);
            apply(~v);
            compare(128'(pin_w), 128'(pins_of(v)));
            compare(got, 128'(pv));
        end
        tester.reset_tap(1'b0);
        apply(PAT_A);
        compare(128'(pin_w), 128'(pins_of(pv)));
    endtask
    task automatic end_of_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_errors++;
            end_of_test;
        end
    end
    // Main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_func;
        t_idcode;
        t_bypass;
        t_chain;
        t_extest;
        end_of_test;
    end
endmodule // scan_port_test
`default_nettype wire
